// file: rsd_pkg.sv
// Behaviour
// - Map 0: code 0 closes switches 1-3; codes 1-3 also close 4, 5 or 6.
// - Map 1: code 0 all open; 1 closes 6,1; 2 closes 5,4,3; 3 closes 5,4,2.
// - Package-map bit resets to 0, the common-anode arrangement.
// - Codes 1,2,3 route current code 4,5,6 to the DAC; code 0 routes none.
// - On a colour change open the leaving switches first, then close new ones.
// - The open-to-close gap equals the programmed dead time; a dead time of 0 gives a 1-cycle gap.
// - Switches closed before and after a change stay closed through the gap.
// - Three independent 10-bit current codes accept any value up to 0x3ff.
// - Transient limit level comes from a 3-bit field of the regulation register.
// - Three enable bits in that register pick which switches get limiting.
// - A 3-bit select picks one of eight measurement multiplexer inputs.
// - Select 0-3: sensor b, LED rail, battery, sensor a; 4-7: sense nodes.
// - Rising above the warning threshold raises a hot-die event.
// - Above the shutdown threshold all rails go off and the shutdown flag sets.
// - After cooling 15 degrees rails restart; regulator enable is not cleared.
// - The package-map bit sits in the system control register.
// - Decoder and LED driver enable only after all three regulator rails are up.
// - Colour-select inputs are deglitched for about 300 ns before use.
package rsd_pkg;

  localparam int unsigned CLK_MHZ      = 100;
  localparam int unsigned DEGLITCH_NS  = 300;
  localparam int unsigned DEGLITCH_CYC = DEGLITCH_NS * CLK_MHZ / 1000;

  localparam int unsigned AW = 8;
  localparam int unsigned DW = 32;
  localparam int unsigned CW = 10;

  localparam logic [AW-1:0] ADDR_SYSTEM  = 8'h00;
  localparam logic [AW-1:0] ADDR_CODE4   = 8'h04;
  localparam logic [AW-1:0] ADDR_CODE5   = 8'h08;
  localparam logic [AW-1:0] ADDR_CODE6   = 8'h0c;
  localparam logic [AW-1:0] ADDR_DEAD    = 8'h10;
  localparam logic [AW-1:0] ADDR_CURRENT_REGULATION_CONTROL    = 8'h14;
  localparam logic [AW-1:0] ADDR_MEASURE = 8'h18;
  localparam logic [AW-1:0] ADDR_STATUS  = 8'h1c;

  // System control fields
  localparam int unsigned SYS_MAP_BIT    = 0;
  localparam int unsigned SYS_REGEN_BIT  = 1;
  localparam int unsigned SYS_LEDEN_BIT  = 2;
  localparam logic [2:0]  SYS_RESET      = 3'h6;

  // Regulation control fields
  localparam int unsigned CURRENT_REGULATION_CONTROL_LIM_LSB   = 0;
  localparam int unsigned CURRENT_REGULATION_CONTROL_EN_LSB    = 4;

  // Measurement fields
  localparam int unsigned MEAS_SEL_LSB   = 0;
  localparam int unsigned MEAS_GAIN_LSB  = 4;
  localparam int unsigned MEAS_CAL_BIT   = 8;

  // Status fields
  localparam int unsigned ST_HOT_BIT     = 0;
  localparam int unsigned ST_TSD_BIT     = 1;
  localparam int unsigned ST_HOT_LVL_BIT = 4;
  localparam int unsigned ST_TSD_LVL_BIT = 5;
  localparam int unsigned ST_RAILS_BIT   = 8;
  localparam int unsigned ST_DEC_BIT     = 9;
  localparam int unsigned ST_SW_LSB      = 16;

  localparam logic [7:0]  DEAD_RESET     = 8'h0a;
  localparam logic [CW-1:0] CODE_RESET   = 10'h000;

  typedef enum logic [2:0] {
    RSD_HOLD = 3'b001,
    RSD_DEAD = 3'b010,
    RSD_OFF  = 3'b100
  } rsd_state_t;

endpackage : rsd_pkg

// file: rsd_deglitch.sv
`timescale 1ns/1ps
module rsd_deglitch #(
  parameter int unsigned WIDTH = 2,
  parameter int unsigned CYC   = rsd_pkg::DEGLITCH_CYC
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] raw,
  output logic      [WIDTH-1:0] clean
);
  import rsd_pkg::*;

  localparam int unsigned CNTW = $clog2(CYC + 1);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] cand_r;
  logic [CNTW-1:0]  cnt_r;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= raw;
      sync_r <= meta_r;
    end
  end

  // A code must hold steady for the full window before it is passed on
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cand_r <= '0;
      cnt_r  <= '0;
      clean  <= '0;
    end else if (sync_r != cand_r) begin
      cand_r <= sync_r;
      cnt_r  <= '0;
    end else if (cnt_r < CNTW'(CYC - 1)) begin
      cnt_r <= cnt_r + 1'b1;
    end else begin
      clean <= cand_r;
    end
  end

endmodule : rsd_deglitch

// file: rsd_top.sv
`timescale 1ns/1ps
module rsd_top (
  input  wire logic                     clk,
  input  wire logic                     reset_n,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [rsd_pkg::AW-1:0]   paddr,
  input  wire logic [rsd_pkg::DW-1:0]   pwdata,
  output logic      [rsd_pkg::DW-1:0]   prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic [1:0]               colour_select,
  input  wire logic                     rails_up,
  input  wire logic                     temp_hot,
  input  wire logic                     temp_shutdown,
  input  wire logic                     temp_cooled,
  output logic      [5:0]               strobe_switch,
  output logic      [rsd_pkg::CW-1:0]   current_dac_code,
  output logic                          current_dac_valid,
  output logic      [2:0]               transient_limit_level,
  output logic      [2:0]               transient_limit_enable,
  output logic      [2:0]               measure_input_select,
  output logic      [1:0]               measure_gain_select,
  output logic                          measure_calibration_disable,
  output logic                          rails_enable,
  output logic                          hot_event,
  output logic                          decoder_enable
);
  import rsd_pkg::*;

  // Switch vector bit n drives strobe switch n+1
  function automatic logic [5:0] switch_map(input logic map, input logic [1:0] colour);
    logic [5:0] s;
    s = 6'h00;
    if (!map) begin
      case (colour)
        2'h0:    s = 6'h07;
        2'h1:    s = 6'h0f;
        2'h2:    s = 6'h17;
        default: s = 6'h27;
      endcase
    end else begin
      case (colour)
        2'h0:    s = 6'h00;
        2'h1:    s = 6'h21;
        2'h2:    s = 6'h1c;
        default: s = 6'h1a;
      endcase
    end
    return s;
  endfunction : switch_map

  function automatic logic [DW-1:0] pad(input logic [CW-1:0] v);
    return {{(DW-CW){1'b0}}, v};
  endfunction : pad

  logic [2:0]     sys_r;
  logic [CW-1:0]  code4_r;
  logic [CW-1:0]  code5_r;
  logic [CW-1:0]  code6_r;
  logic [7:0]     dead_r;
  logic [2:0]     ilim_r;
  logic [2:0]     ilim_en_r;
  logic [2:0]     msel_r;
  logic [1:0]     mgain_r;
  logic           mcal_r;
  logic           hot_flag_r;
  logic           tsd_flag_r;
  logic           hot_prev_r;
  logic           tsd_prev_r;
  logic           tsd_active_r;

  logic [1:0]     colour_clean;
  logic           wr_en;
  logic           setup;
  logic           mapped;
  logic [DW-1:0]  rd_nxt;
  logic           run;
  logic [5:0]     target;

  rsd_state_t     state_r;
  logic [7:0]     cnt_r;
  logic [5:0]     goal_r;
  logic [1:0]     goal_colour_r;

  rsd_deglitch #(
    .WIDTH (2),
    .CYC   (DEGLITCH_CYC)
  ) u_deglitch (
    .clk     (clk),
    .reset_n (reset_n),
    .raw     (colour_select),
    .clean   (colour_clean)
  );

  // APB: zero wait states, access phase is a single cycle
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pready && pwrite;

  always_comb begin
    mapped = 1'b1;
    rd_nxt = '0;
    case (paddr)
      ADDR_SYSTEM:  rd_nxt = {29'h0, sys_r};
      ADDR_CODE4:   rd_nxt = pad(code4_r);
      ADDR_CODE5:   rd_nxt = pad(code5_r);
      ADDR_CODE6:   rd_nxt = pad(code6_r);
      ADDR_DEAD:    rd_nxt = {24'h0, dead_r};
      ADDR_CURRENT_REGULATION_CONTROL:    rd_nxt = {25'h0, ilim_en_r, 1'b0, ilim_r};
      ADDR_MEASURE: rd_nxt = {23'h0, mcal_r, 2'h0, mgain_r, 1'b0, msel_r};
      ADDR_STATUS: begin
        rd_nxt[ST_HOT_BIT]              = hot_flag_r;
        rd_nxt[ST_TSD_BIT]              = tsd_flag_r;
        rd_nxt[ST_HOT_LVL_BIT]          = temp_hot;
        rd_nxt[ST_TSD_LVL_BIT]          = tsd_active_r;
        rd_nxt[ST_RAILS_BIT]            = rails_up;
        rd_nxt[ST_DEC_BIT]              = decoder_enable;
        rd_nxt[ST_SW_LSB +: 6]          = strobe_switch;
      end
      default:      mapped = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= setup;
      pslverr <= setup && !mapped;
      if (setup && !pwrite) begin
        prdata <= rd_nxt;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sys_r <= SYS_RESET;
    end else if (wr_en && paddr == ADDR_SYSTEM) begin
      sys_r <= pwdata[2:0];
    end
  end

  // Full 10-bit range accepted without clamping
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      code4_r <= CODE_RESET;
      code5_r <= CODE_RESET;
      code6_r <= CODE_RESET;
    end else if (wr_en) begin
      if (paddr == ADDR_CODE4) code4_r <= pwdata[CW-1:0];
      if (paddr == ADDR_CODE5) code5_r <= pwdata[CW-1:0];
      if (paddr == ADDR_CODE6) code6_r <= pwdata[CW-1:0];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dead_r    <= DEAD_RESET;
      ilim_r    <= 3'h0;
      ilim_en_r <= 3'h0;
    end else if (wr_en) begin
      if (paddr == ADDR_DEAD) dead_r <= pwdata[7:0];
      if (paddr == ADDR_CURRENT_REGULATION_CONTROL) begin
        ilim_r    <= pwdata[CURRENT_REGULATION_CONTROL_LIM_LSB +: 3];
        ilim_en_r <= pwdata[CURRENT_REGULATION_CONTROL_EN_LSB +: 3];
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      msel_r  <= 3'h0;
      mgain_r <= 2'h0;
      mcal_r  <= 1'b0;
    end else if (wr_en && paddr == ADDR_MEASURE) begin
      msel_r  <= pwdata[MEAS_SEL_LSB +: 3];
      mgain_r <= pwdata[MEAS_GAIN_LSB +: 2];
      mcal_r  <= pwdata[MEAS_CAL_BIT];
    end
  end

  // Select code drives the analog mux directly; order of inputs is fixed there
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      measure_input_select        <= 3'h0;
      measure_gain_select         <= 2'h0;
      measure_calibration_disable <= 1'b0;
    end else begin
      measure_input_select        <= msel_r;
      measure_gain_select         <= mgain_r;
      measure_calibration_disable <= mcal_r;
    end
  end

  // Thermal: shutdown holds until the cooled comparator says so
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hot_prev_r   <= 1'b0;
      tsd_prev_r   <= 1'b0;
      tsd_active_r <= 1'b0;
      hot_event    <= 1'b0;
    end else begin
      hot_prev_r <= temp_hot;
      tsd_prev_r <= temp_shutdown;
      hot_event  <= temp_hot && !hot_prev_r;
      if (temp_shutdown) begin
        tsd_active_r <= 1'b1;
      end else if (temp_cooled) begin
        tsd_active_r <= 1'b0;
      end
    end
  end

  // Sticky flags, write one to clear; a new event in the same cycle wins
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hot_flag_r <= 1'b0;
      tsd_flag_r <= 1'b0;
    end else begin
      if (temp_hot && !hot_prev_r) begin
        hot_flag_r <= 1'b1;
      end else if (wr_en && paddr == ADDR_STATUS && pwdata[ST_HOT_BIT]) begin
        hot_flag_r <= 1'b0;
      end
      if (temp_shutdown && !tsd_prev_r) begin
        tsd_flag_r <= 1'b1;
      end else if (wr_en && paddr == ADDR_STATUS && pwdata[ST_TSD_BIT]) begin
        tsd_flag_r <= 1'b0;
      end
    end
  end

  // Regulator enable bit is left untouched by shutdown, so recovery is automatic
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rails_enable   <= 1'b0;
      decoder_enable <= 1'b0;
    end else begin
      rails_enable   <= sys_r[SYS_REGEN_BIT] && !tsd_active_r && !temp_shutdown;
      decoder_enable <= run;
    end
  end

  assign run    = rails_up && rails_enable && sys_r[SYS_LEDEN_BIT] && !tsd_active_r;
  assign target = run ? switch_map(sys_r[SYS_MAP_BIT], colour_clean) : 6'h00;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      transient_limit_level  <= 3'h0;
      transient_limit_enable <= 3'h0;
    end else begin
      transient_limit_level  <= ilim_r;
      transient_limit_enable <= ilim_en_r;
    end
  end

  // Break-before-make sequencer; switches and DAC change only on clock edges
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r       <= RSD_OFF;
      strobe_switch <= 6'h00;
      goal_r        <= 6'h00;
      goal_colour_r <= 2'h0;
      cnt_r         <= 8'h00;
    end else begin
      case (state_r)
        RSD_OFF: begin
          strobe_switch <= 6'h00;
          // Forget the old pattern so a restart rebuilds it through the gap
          goal_r        <= 6'h00;
          goal_colour_r <= 2'h0;
          if (run) begin
            state_r <= RSD_HOLD;
          end
        end
        RSD_HOLD: begin
          if (!run) begin
            strobe_switch <= 6'h00;
            state_r       <= RSD_OFF;
          end else if (target != goal_r || colour_clean != goal_colour_r) begin
            goal_r        <= target;
            goal_colour_r <= colour_clean;
            if ((target & ~strobe_switch) == 6'h00) begin
              strobe_switch <= target;
            end else begin
              strobe_switch <= strobe_switch & target;
              cnt_r         <= dead_r;
              state_r       <= RSD_DEAD;
            end
          end
        end
        RSD_DEAD: begin
          if (!run) begin
            strobe_switch <= 6'h00;
            state_r       <= RSD_OFF;
          end else if (target != goal_r) begin
            // Code moved during the gap: drop anything no longer wanted, restart
            goal_r        <= target;
            goal_colour_r <= colour_clean;
            strobe_switch <= strobe_switch & target;
            cnt_r         <= dead_r;
          end else if (cnt_r <= 8'h01) begin
            strobe_switch <= goal_r;
            state_r       <= RSD_HOLD;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        default: begin
          strobe_switch <= 6'h00;
          state_r       <= RSD_OFF;
        end
      endcase
    end
  end

  // DAC code follows the goal colour, which updates when a change starts, before its switches close
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      current_dac_code  <= CODE_RESET;
      current_dac_valid <= 1'b0;
    end else begin
      // Valid only on a settled pattern, never while a change is pending
      current_dac_valid <= (state_r == RSD_HOLD) && run && (goal_colour_r != 2'h0) &&
                           (target == goal_r) && (colour_clean == goal_colour_r);
      case (goal_colour_r)
        2'h1:    current_dac_code <= code4_r;
        2'h2:    current_dac_code <= code5_r;
        2'h3:    current_dac_code <= code6_r;
        default: current_dac_code <= CODE_RESET;
      endcase
    end
  end

endmodule : rsd_top

// file: rsd_monitor.sv
`timescale 1ns/1ps
module rsd_monitor (
  input wire logic                   clk,
  input wire logic                   reset_n,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [rsd_pkg::AW-1:0] paddr,
  input wire logic [rsd_pkg::DW-1:0] pwdata,
  input wire logic                   pready,
  input wire logic                   pslverr,
  input wire logic                   rails_up,
  input wire logic                   temp_hot,
  input wire logic                   temp_shutdown,
  input wire logic [5:0]             strobe_switch,
  input wire logic                   current_dac_valid,
  input wire logic                   rails_enable,
  input wire logic                   hot_event,
  input wire logic                   decoder_enable
);
  import rsd_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic [5:0] sw_q;
  logic [7:0] gap_r;
  logic [7:0] dead_r;
  logic       map_r;
  wire        wr_ok = psel && penable && pready && pwrite && !pslverr;
  wire  [7:0] dead_eff = (dead_r == 8'h00) ? 8'h01 : dead_r;
  wire        opening = |(sw_q & ~strobe_switch);
  wire        closing = |(~sw_q & strobe_switch);

  // Gap saturates so that slow re-enables after an outage are not judged
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sw_q <= 6'h00;
      gap_r <= 8'hff;
    end else begin
      sw_q <= strobe_switch;
      if (opening) gap_r <= 8'h01;
      else if (gap_r != 8'hff) gap_r <= gap_r + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dead_r <= DEAD_RESET;
      map_r <= 1'b0;
    end else if (wr_ok) begin
      if (paddr == ADDR_DEAD) dead_r <= pwdata[7:0];
      if (paddr == ADDR_SYSTEM) map_r <= pwdata[SYS_MAP_BIT];
    end
  end

  property p_bbm; !(opening && closing); endproperty
  property p_dead; closing |-> gap_r >= dead_eff; endproperty
  property p_keep;
    decoder_enable && rails_up && !temp_shutdown && !map_r && sw_q[2:0] == 3'h7
      |-> strobe_switch[2:0] == 3'h7;
  endproperty
  property p_dac;
    current_dac_valid |-> strobe_switch inside {6'h0f, 6'h17, 6'h27, 6'h21, 6'h1c, 6'h1a};
  endproperty
  property p_hot; $rose(temp_hot) |-> ##[0:3] hot_event; endproperty
  property p_hot1; hot_event |=> !hot_event; endproperty
  property p_tsd; temp_shutdown |-> ##[0:3] (!rails_enable && strobe_switch == 6'h00); endproperty
  property p_off; !decoder_enable ##1 !decoder_enable |-> strobe_switch == 6'h00; endproperty
  property p_dec; !rails_up |-> ##[0:3] !decoder_enable; endproperty
  property p_ready; psel && !penable |=> pready; endproperty
  property p_err; pready && paddr > ADDR_STATUS |-> pslverr; endproperty

  a_bbm: assert property (p_bbm) else $error("switch opened and closed together");
  a_dead: assert property (p_dead) else $error("switch closed before dead time");
  a_keep: assert property (p_keep) else $error("shared switch opened");
  a_dac: assert property (p_dac) else $error("dac valid on odd pattern");
  a_hot: assert property (p_hot) else $error("hot event missing");
  a_hot1: assert property (p_hot1) else $error("hot event too long");
  a_tsd: assert property (p_tsd) else $error("shutdown left rails on");
  a_off: assert property (p_off) else $error("switch closed while disabled");
  a_dec: assert property (p_dec) else $error("decoder on without rails");
  a_ready: assert property (p_ready) else $error("no ready after setup");
  a_err: assert property (p_err) else $error("no error on unmapped");

  c_close: cover property (closing && gap_r == dead_eff);
  c_hot: cover property (hot_event);
  c_err: cover property (pslverr);
  c_tsd: cover property ($rose(temp_shutdown));
endmodule : rsd_monitor

bind rsd_top rsd_monitor u_mon (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pready, .pslverr, .rails_up, .temp_hot, .temp_shutdown, .strobe_switch,
  .current_dac_valid, .rails_enable, .hot_event, .decoder_enable);

// file: rsd_ctrl_model.sv
`timescale 1ns/1ps
module rsd_ctrl_model (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       run,
  input  wire logic [7:0] dwell,
  input  wire logic [1:0] park,
  output logic      [1:0] colour_select
);
  logic [7:0] cnt_r;
  // Short dwell gives codes too brief to pass the deglitch filter
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= 8'h00;
      colour_select <= 2'h0;
    end else if (!run) begin
      cnt_r <= 8'h00;
      colour_select <= park;
    end else if (cnt_r >= dwell) begin
      cnt_r <= 8'h00;
      colour_select <= (colour_select == 2'h3) ? 2'h1 : colour_select + 2'h1;
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end
endmodule : rsd_ctrl_model

// file: rsd_top_tb.sv
`timescale 1ns/1ps
module rsd_top_tb;
  import rsd_pkg::*;
  logic          clk, reset_n, psel, penable, pwrite, pready, pslverr, perr;
  logic [AW-1:0] paddr;
  logic [DW-1:0] pwdata, prdata, rdat;
  logic          rails_up, temp_hot, temp_shutdown, temp_cooled, run;
  logic          current_dac_valid, rails_enable, hot_event, decoder_enable;
  logic          measure_calibration_disable;
  logic [1:0]    colour_select, park, measure_gain_select;
  logic [7:0]    dwell;
  logic [5:0]    strobe_switch;
  logic [CW-1:0] current_dac_code;
  logic [2:0]    transient_limit_level, transient_limit_enable, measure_input_select;
  int            fails, total_checks;
  logic [CW-1:0] codes [3] = '{10'h3ff, 10'h155, 10'h2aa};
  logic [5:0]    sw_tab [8] = '{6'h07, 6'h0f, 6'h17, 6'h27, 6'h00, 6'h21, 6'h1c, 6'h1a};

  rsd_top uut (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .colour_select, .rails_up, .temp_hot, .temp_shutdown, .temp_cooled,
    .strobe_switch, .current_dac_code, .current_dac_valid, .transient_limit_level,
    .transient_limit_enable, .measure_input_select, .measure_gain_select,
    .measure_calibration_disable, .rails_enable, .hot_event, .decoder_enable);
  rsd_ctrl_model u_ctrl (.clk, .reset_n, .run, .dwell, .park, .colour_select);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdat = prdata;
    perr = pslverr;
    if (n >= 20) begin
      fails++;
      conclude();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  // Waits are bounded; a stuck output shows up as a mismatch
  task automatic wait_sw(input logic [5:0] exp);
    int n;
    n = 0;
    while (strobe_switch !== exp && n < 200) begin
      @(posedge clk);
      n++;
    end
    chk(strobe_switch, exp, "switches");
  endtask : wait_sw

  task automatic wait_bit(ref logic s, input logic v, input string what);
    int n;
    n = 0;
    while (s !== v && n < 400) begin
      @(posedge clk);
      n++;
    end
    chk(s, v, what);
  endtask : wait_bit

  task automatic t_regs;
    apb(1'b0, ADDR_SYSTEM, '0);
    chk(rdat, 32'h6, "system reset");
    apb(1'b0, ADDR_DEAD, '0);
    chk(rdat, 32'h0a, "dead reset");
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, ADDR_CODE4 + 8'(i * 4), {22'h0, codes[i]});
      apb(1'b0, ADDR_CODE4 + 8'(i * 4), '0);
      chk(rdat, {22'h0, codes[i]}, "current code");
    end
    apb(1'b0, 8'h20, '0);
    chk(perr, 1'b1, "unmapped error");
    chk(rdat, 32'h0, "unmapped data");
  endtask : t_regs

  task automatic t_fields;
    logic [2:0] s;
    logic [1:0] g;
    apb(1'b1, ADDR_CURRENT_REGULATION_CONTROL, 32'h55);
    @(posedge clk);
    chk({transient_limit_enable, transient_limit_level}, 6'h2d, "limit");
    apb(1'b1, ADDR_CURRENT_REGULATION_CONTROL, 32'h13);
    @(posedge clk);
    chk({transient_limit_enable, transient_limit_level}, 6'h0b, "red limit");
    for (int i = 0; i < 8; i++) begin
      s = 3'(i);
      g = s[2] ? 2'h2 : 2'h1;
      apb(1'b1, ADDR_MEASURE, {23'h0, s[0], 2'h0, g, 1'b0, s});
      @(posedge clk);
      chk({measure_calibration_disable, measure_gain_select, measure_input_select},
          {s[0], g, s}, "measure");
    end
  endtask : t_fields

  task automatic t_decode;
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, ADDR_SYSTEM, 32'h6 | 32'(m));
      for (int c = 0; c < 4; c++) begin
        park <= 2'(c);
        wait_sw(sw_tab[m * 4 + c]);
        repeat (3) @(posedge clk);
        chk(current_dac_valid, c != 0, "dac valid");
        if (c != 0) chk(current_dac_code, codes[c - 1], "dac code");
      end
    end
    apb(1'b1, ADDR_SYSTEM, 32'h6);
  endtask : t_decode

  task automatic t_dead(input logic [7:0] dt);
    int   k;
    logic bad;
    k = 0;
    bad = 1'b0;
    apb(1'b1, ADDR_DEAD, {24'h0, dt});
    park <= 2'h1;
    wait_sw(6'h0f);
    park <= 2'h2;
    wait_sw(6'h07);
    while (strobe_switch !== 6'h17 && k < 300) begin
      @(posedge clk);
      k++;
      if (strobe_switch[2:0] !== 3'h7) bad = 1'b1;
    end
    chk(k, (dt == 8'h00) ? 32'h1 : {24'h0, dt}, "dead time");
    chk(bad, 1'b0, "held switches");
  endtask : t_dead

  task automatic t_rotate;
    logic       bad;
    logic [2:0] seen;
    bad = 1'b0;
    seen = 3'h0;
    dwell <= 8'h04;
    run <= 1'b1;
    repeat (80) begin
      @(posedge clk);
      if (strobe_switch !== 6'h17) bad = 1'b1;
    end
    chk(bad, 1'b0, "glitch passed");
    dwell <= 8'h3c;
    repeat (400) begin
      @(posedge clk);
      seen = seen | strobe_switch[5:3];
    end
    chk(seen, 3'h7, "rotation");
    run <= 1'b0;
    park <= 2'h1;
    wait_sw(6'h0f);
  endtask : t_rotate

  task automatic t_thermal;
    temp_hot <= 1'b1;
    wait_bit(hot_event, 1'b1, "hot event");
    temp_hot <= 1'b0;
    apb(1'b0, ADDR_STATUS, '0);
    chk(rdat[1:0], 2'h1, "hot flag");
    apb(1'b1, ADDR_STATUS, 32'h1);
    apb(1'b0, ADDR_STATUS, '0);
    chk(rdat[1:0], 2'h0, "hot cleared");
    temp_shutdown <= 1'b1;
    wait_bit(rails_enable, 1'b0, "shutdown");
    wait_sw(6'h00);
    apb(1'b0, ADDR_STATUS, '0);
    chk(rdat[1], 1'b1, "shutdown flag");
    apb(1'b0, ADDR_SYSTEM, '0);
    chk(rdat[1], 1'b1, "regulator bit kept");
    repeat (300) @(posedge clk);
    temp_shutdown <= 1'b0;
    temp_cooled <= 1'b1;
    wait_bit(rails_enable, 1'b1, "restart");
    temp_cooled <= 1'b0;
    wait_sw(6'h0f);
    rails_up <= 1'b0;
    wait_bit(decoder_enable, 1'b0, "rails down");
    chk(strobe_switch, 6'h00, "rails down switches");
    repeat (300) @(posedge clk);
    rails_up <= 1'b1;
    wait_sw(6'h0f);
  endtask : t_thermal

  initial begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    rails_up = 1'b1;
    temp_hot = 1'b0;
    temp_shutdown = 1'b0;
    temp_cooled = 1'b0;
    run = 1'b0;
    dwell = 8'h3c;
    park = 2'h0;
    fails = 0;
    total_checks = 0;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_fields();
    t_decode();
    t_dead(8'h03);
    t_dead(8'h00);
    t_dead(8'h0a);
    t_rotate();
    t_thermal();
    conclude();
  end
endmodule : rsd_top_tb
